//--- rstc_pkg.sv
// shared constants and types of the system reset controller
package rstc_pkg;
   // register offsets
   localparam logic [7:0] ADDR_CAUSE = 8'h00;
   localparam logic [7:0] ADDR_SWTRIG = 8'h01;
   // cause flag positions
   localparam int FLAG_POWERUP = 0;
   localparam int FLAG_BROWNOUT = 1;
   localparam int FLAG_PIN = 2;
   localparam int FLAG_WATCHDOG = 3;
   localparam int FLAG_SOFT = 4;
   localparam int FLAG_DEBUG = 5;
   localparam int SWTRIG_BIT = 0;
   // reset values
   localparam logic [5:0] CAUSE_RST = 6'h00;
   localparam logic [5:0] CAUSE_POWERUP_ONLY = 6'h01;
   localparam logic [2:0] UNLOCK_RST = 3'h0;
   // unlock window, in cpu instructions
   localparam logic [2:0] UNLOCK_INSTR = 3'h4;
   // timing: clock rate and start-up delay step
   localparam int CLK_MHZ = 250;
   localparam int STARTUP_STEP_NS = 1000;
   localparam int STARTUP_STEP_CYC = (STARTUP_STEP_NS * CLK_MHZ + 999) / 1000;
   localparam int FUSE_LOAD_CYC = 8;
   // sequencer states
   typedef enum logic [2:0] {
      ST_RUN = 3'b000,
      ST_HOLD = 3'b001,
      ST_FUSE = 3'b010,
      ST_START = 3'b011,
      ST_SCAN = 3'b100
   } rstc_state_e;
endpackage

//--- system_reset_controller.sv
// system reset controller: source collection, sequencing, cause flags
//
// Overview of operation
// - controller always on; brown-out, pin and watchdog sources gated by enables
// - every reset reloads fuse-backed registers
// - cause flags show source of last reset
// - power-on low supply holds reset through sequence
// - enabled reset pin low holds reset
// - watchdog time-out issues a reset
// - writing trigger bit one resets at once
// - trigger bit always reads zero
// - debug reset only from debug interface
// - only power resets reset debug logic
// - start-up delay only after power resets
// - memory scan extends initialization when enabled
// - runs in active and all sleep modes
// - unlock key then write within four instructions
// - locked write changes nothing, no reset
// - write one clears flag, zero keeps
// - power-on clears all flags but its own
// - flags bits five down to zero
// - after power-on, other flags wait for boot
`timescale 1ns/100ps
module system_reset_controller #(
   parameter int STEP_CYC = rstc_pkg::STARTUP_STEP_CYC, // cycles per start-up step
   parameter int FUSE_CYC = rstc_pkg::FUSE_LOAD_CYC     // fuse reload length
) (
   input wire logic ref_clk,            // peripheral clock
   input wire logic rst,                // async reset, active high
   input wire logic powerupLow,         // power-on detector, async
   input wire logic brownoutLow,        // brown-out detector, async
   input wire logic resetPinN,          // reset pin, async, active low
   input wire logic brownoutEn,         // brown-out source enable
   input wire logic pinResetEn,         // reset pin fuse enable
   input wire logic watchdogEn,         // watchdog source enable
   input wire logic watchdogExpire,     // watchdog time-out, same clock
   input wire logic debugPortReq,       // debug interface reset request
   input wire logic [2:0] startupSel,   // start-up delay setting
   input wire logic memScanAtStart,     // memory scan at start-up fuse
   input wire logic memScanDone,        // memory scan finished
   input wire logic unlockKeyWr,        // key written to unlock register
   input wire logic instrDone,          // one cpu instruction retired
   input wire logic [7:0] regAddr,      // register address
   input wire logic [7:0] wrData,       // write data
   input wire logic wrStb,              // write strobe
   input wire logic rdStb,              // read strobe
   output logic [7:0] rdData,           // read data, cycle after strobe
   output logic sysReset,               // system reset
   output logic fuseReload,             // fuse reload in progress
   output logic debugLogicReset         // reset of debug logic
);
   //////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      rstc_pkg::rstc_state_e state; // sequencer state
      logic [5:0] cause;            // cause flags
      logic [2:0] unlockCnt;        // instructions left in unlock window
      logic [15:0] cnt;             // phase counter
      logic swPend;                 // software trigger accepted
      logic pwrCause;               // sequence caused by power source
      logic bootDone;               // full boot ran since power-on
      logic sysRst;                 // registered reset output
      logic fuseLd;                 // registered fuse reload output
      logic dbgRst;                 // registered debug reset output
      logic [7:0] rd;               // registered read data
      logic [1:0] porS;             // power-on synchroniser
      logic [1:0] bodS;             // brown-out synchroniser
      logic [1:0] pinS;             // reset pin synchroniser
   } rstc_regs_s;

   rstc_regs_s q;
   rstc_regs_s d;
   logic porAct;       // power-on source active
   logic bodAct;       // brown-out source active
   logic pinAct;       // pin source active
   logic wdtAct;       // watchdog source active
   logic dbgAct;       // debug source active
   logic anyAct;       // any source active
   logic unlocked;     // unlock window open
   logic [5:0] setVec; // flags requested this cycle
   logic swWr;         // write to trigger register
   logic [15:0] startLen; // start-up delay length

   //////////////////////////////////////////////////////////////////
   // source qualification
   // enables on brown-out, pin and watchdog sources
   assign porAct = q.porS[1];
   assign bodAct = q.bodS[1] & brownoutEn;
   assign pinAct = ~q.pinS[1] & pinResetEn;
   assign wdtAct = watchdogExpire & watchdogEn;
   assign dbgAct = debugPortReq;
   assign anyAct = porAct | bodAct | pinAct | wdtAct | dbgAct | q.swPend;
   assign setVec = {dbgAct, q.swPend, wdtAct, pinAct, bodAct, porAct};
   assign unlocked = q.unlockCnt != 3'h0;
   assign swWr = wrStb && regAddr == rstc_pkg::ADDR_SWTRIG;
   // product cut to 16 bits: setting times step stays far below 16 bits
   assign startLen = 16'(int'(startupSel) * STEP_CYC);

   //////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d = q;
      // two-flop synchronisers, first stage read only by second
      d.porS = {q.porS[0], powerupLow};
      d.bodS = {q.bodS[0], brownoutLow};
      d.pinS = {q.pinS[0], resetPinN};
      if (unlockKeyWr) begin
         d.unlockCnt = rstc_pkg::UNLOCK_INSTR;
      end else if (swWr && unlocked) begin
         d.unlockCnt = 3'h0; // one protected write per key
      end else if (instrDone && unlocked) begin
         d.unlockCnt = q.unlockCnt - 3'h1;
      end
      d.swPend = swWr && unlocked && wrData[rstc_pkg::SWTRIG_BIT];
      if (wrStb && regAddr == rstc_pkg::ADDR_CAUSE) begin
         d.cause = q.cause & ~wrData[5:0];
      end
      // set after clear so a new event is never lost
      if (porAct) begin
         d.cause = rstc_pkg::CAUSE_POWERUP_ONLY;
         d.bootDone = 1'b0;
      end else if (q.bootDone) begin
         d.cause = d.cause | setVec;
      end
      // sequencer; no sleep input, so it never stops
      // always running
      if (anyAct) begin
         d.state = rstc_pkg::ST_HOLD;
         d.pwrCause = q.pwrCause | porAct | bodAct;
      end else begin
         case (q.state)
            rstc_pkg::ST_RUN: begin
               d.pwrCause = 1'b0;
            end
            rstc_pkg::ST_HOLD: begin
               d.state = rstc_pkg::ST_FUSE;
               d.cnt = 16'(FUSE_CYC - 1);
            end
            rstc_pkg::ST_FUSE: begin
               d.cnt = q.cnt - 16'h1;
               if (q.cnt == 16'h0) begin
                  if (q.pwrCause && startLen != 16'h0) begin
                     d.state = rstc_pkg::ST_START;
                     d.cnt = startLen - 16'h1;
                  end else if (memScanAtStart) begin
                     d.state = rstc_pkg::ST_SCAN;
                  end else begin
                     d.state = rstc_pkg::ST_RUN;
                  end
               end
            end
            rstc_pkg::ST_START: begin
               d.cnt = q.cnt - 16'h1;
               if (q.cnt == 16'h0) begin
                  d.state = memScanAtStart ? rstc_pkg::ST_SCAN : rstc_pkg::ST_RUN;
               end
            end
            rstc_pkg::ST_SCAN: begin
               if (memScanDone) begin
                  d.state = rstc_pkg::ST_RUN;
               end
            end
            default: begin
               d.state = rstc_pkg::ST_HOLD;
            end
         endcase
      end
      if (d.state == rstc_pkg::ST_RUN && q.state != rstc_pkg::ST_RUN) begin
         d.bootDone = 1'b1;
      end
      d.sysRst = d.state != rstc_pkg::ST_RUN;
      d.fuseLd = d.state == rstc_pkg::ST_FUSE;
      d.dbgRst = d.sysRst && d.pwrCause;
      // read data stands one cycle
      d.rd = 8'h00;
      if (rdStb) begin
         if (regAddr == rstc_pkg::ADDR_CAUSE) begin
            d.rd = {2'b00, q.cause};
         end else if (regAddr == rstc_pkg::ADDR_SWTRIG) begin
            d.rd = 8'h00;
         end
      end
   end

   //////////////////////////////////////////////////////////////////
   // registers; reset assumes supply just came up
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         q <= '{state: rstc_pkg::ST_HOLD, cause: rstc_pkg::CAUSE_RST,
                unlockCnt: rstc_pkg::UNLOCK_RST, cnt: 16'h0000, swPend: 1'b0,
                pwrCause: 1'b1, bootDone: 1'b0, sysRst: 1'b1, fuseLd: 1'b0,
                dbgRst: 1'b1, rd: 8'h00, porS: 2'b11, bodS: 2'b00, pinS: 2'b11};
      end else begin
         q <= d;
      end
   end

   assign rdData = q.rd;
   assign sysReset = q.sysRst;
   assign fuseReload = q.fuseLd;
   assign debugLogicReset = q.dbgRst;

   //////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence swUnlockedWrite;
      swWr && unlocked && wrData[0];
   endsequence
   sequence swLockedWrite;
      swWr && !unlocked;
   endsequence

   AST_SWTRIG_READ_ZERO: assert property (
      rdStb && regAddr == rstc_pkg::ADDR_SWTRIG |=> rdData == 8'h00)
      else $error("trigger register read not zero");
   AST_SW_RESET_NOW: assert property (
      swUnlockedWrite |=> ##1 sysReset)
      else $error("software trigger did not reset");
   AST_LOCKED_IGNORED: assert property (
      swLockedWrite |=> !q.swPend)
      else $error("locked write accepted");
   AST_W1C_POWERUP: assert property (
      wrStb && regAddr == rstc_pkg::ADDR_CAUSE && wrData[0] && !porAct |=> !q.cause[0])
      else $error("flag not cleared by write one");
   AST_POWERUP_FLAGS: assert property (
      porAct |=> q.cause == rstc_pkg::CAUSE_POWERUP_ONLY)
      else $error("power-on flags wrong");
   AST_POWERUP_HOLD: assert property (
      porAct |=> sysReset && debugLogicReset)
      else $error("power-on reset not held");
   AST_PIN_HOLD: assert property (
      pinAct |=> sysReset)
      else $error("pin reset not held");
   AST_FUSE_AFTER_RELEASE: assert property (
      q.state == rstc_pkg::ST_HOLD && !anyAct |=> fuseReload [*2])
      else $error("no fuse reload after release");
   AST_SCAN_EXTENDS: assert property (
      q.state == rstc_pkg::ST_SCAN && !memScanDone && !anyAct |=> sysReset)
      else $error("reset dropped before scan done");
   AST_DEBUG_POWER_ONLY: assert property (
      $rose(sysReset) && !$past(porAct) && !$past(bodAct) && !q.pwrCause |-> !debugLogicReset)
      else $error("debug logic reset by user source");

   // end of fuse reload, split by whether a power source started the sequence
   sequence fuseEndUser;
      q.state == rstc_pkg::ST_FUSE && q.cnt == 16'h0 && !q.pwrCause && !anyAct;
   endsequence
   sequence fuseEndPower;
      q.state == rstc_pkg::ST_FUSE && q.cnt == 16'h0 && q.pwrCause
         && startLen != 16'h0 && !anyAct;
   endsequence

   AST_SOURCE_RESETS: assert property (
      anyAct |=> sysReset)
      else $error("source active without system reset");
   AST_USER_NO_DEBUG: assert property (
      anyAct && !porAct && !bodAct && !q.pwrCause |=> !debugLogicReset)
      else $error("debug logic reset on user reset");
   AST_USER_NO_STARTUP: assert property (
      fuseEndUser |=> q.state != rstc_pkg::ST_START)
      else $error("start-up delay after user reset");
   AST_POWER_STARTUP: assert property (
      fuseEndPower |=> q.state == rstc_pkg::ST_START && sysReset)
      else $error("start-up delay missing after power reset");
   AST_KEY_OPENS: assert property (
      unlockKeyWr |=> q.unlockCnt == rstc_pkg::UNLOCK_INSTR)
      else $error("unlock key did not open window");
   AST_SOFT_FLAG: assert property (
      q.swPend && q.bootDone && !porAct |=> q.cause[rstc_pkg::FLAG_SOFT])
      else $error("software reset flag not set");
   AST_NO_FLAG_BEFORE_BOOT: assert property (
      !q.bootDone && !porAct |=> (q.cause & ~$past(q.cause)) == 6'h00)
      else $error("flag set before boot finished");
   AST_W1C_ALL: assert property (
      wrStb && regAddr == rstc_pkg::ADDR_CAUSE && setVec == 6'h00
         |=> (q.cause & $past(wrData[5:0])) == 6'h00)
      else $error("flag survived write one");
endmodule // system_reset_controller

//--- rstc_far_model.sv
// far side model: reset sources and cpu unlock steps
`timescale 1ns/100ps
module rstc_far_model (
   input wire logic ref_clk, // peripheral clock
   output logic powerupLow, // low supply flag
   output logic brownoutLow, // brown-out trip
   output logic resetPinN, // reset pin, low active
   output logic watchdogExpire, // watchdog time-out
   output logic debugPortReq, // debug reset request
   output logic unlockKeyWr, // key written
   output logic instrDone // instruction retired
);
   // all sources idle, pin pulled high
   initial begin
      {powerupLow, brownoutLow, watchdogExpire, debugPortReq} = 4'h0;
      {unlockKeyWr, instrDone} = 2'h0;
      resetPinN = 1'b1;
   end
   task automatic raise(input logic [4:0] m, input int n);
      @(posedge ref_clk);
      {debugPortReq, watchdogExpire} <= m[4:3];
      resetPinN <= ~m[2];
      {brownoutLow, powerupLow} <= m[1:0];
      repeat (n) @(posedge ref_clk);
      {debugPortReq, watchdogExpire, brownoutLow, powerupLow} <= 4'h0;
      resetPinN <= 1'b1;
   endtask
   task automatic unlock(input int k);
      int i;
      @(posedge ref_clk);
      unlockKeyWr <= 1'b1;
      for (i = 0; i < k; i++) begin
         @(posedge ref_clk);
         unlockKeyWr <= 1'b0;
         instrDone <= 1'b1;
      end
      @(posedge ref_clk);
      {unlockKeyWr, instrDone} <= 2'h0;
   endtask
endmodule // rstc_far_model

//--- tb.sv
// self-checking bench of the system reset controller
`timescale 1ns/100ps
module tb;
   logic ref_clk = 1'b0, rst = 1'b1, wrStb = 1'b0, rdStb = 1'b0;
   logic brownoutEn = 1'b0, pinResetEn = 1'b0, watchdogEn = 1'b0;
   logic [2:0] startupSel = 3'h2; // start-up delay setting
   logic memScanAtStart = 1'b0, memScanDone = 1'b1; // scan fuse and its done level
   logic [7:0] regAddr = 8'h00, wrData = 8'h00, rdData;
   logic powerupLow, brownoutLow, resetPinN, watchdogExpire, debugPortReq;
   logic unlockKeyWr, instrDone, sysReset, fuseReload, debugLogicReset;
   logic [1:0] s; // seen {debug reset, fuse reload}
   int h, fails = 0, n_checks = 0, cyc = 0;
   // short counts keep the boot sequence brief
   localparam int FUSE = 2;
   localparam int STEP = 2;
   system_reset_controller #(.STEP_CYC(STEP), .FUSE_CYC(FUSE)) i_dut (.ref_clk(ref_clk),
      .rst(rst), .powerupLow(powerupLow), .brownoutLow(brownoutLow), .resetPinN(resetPinN),
      .brownoutEn(brownoutEn), .pinResetEn(pinResetEn), .watchdogEn(watchdogEn),
      .watchdogExpire(watchdogExpire), .debugPortReq(debugPortReq), .startupSel(startupSel),
      .memScanAtStart(memScanAtStart), .memScanDone(memScanDone), .unlockKeyWr(unlockKeyWr),
      .instrDone(instrDone), .regAddr(regAddr), .wrData(wrData), .wrStb(wrStb),
      .rdStb(rdStb), .rdData(rdData), .sysReset(sysReset), .fuseReload(fuseReload),
      .debugLogicReset(debugLogicReset));
   rstc_far_model i_far (.ref_clk(ref_clk), .powerupLow(powerupLow),
      .brownoutLow(brownoutLow), .resetPinN(resetPinN), .watchdogExpire(watchdogExpire),
      .debugPortReq(debugPortReq), .unlockKeyWr(unlockKeyWr), .instrDone(instrDone));
   ////////////////////////////////////////////////////////////////////////////////
   // clock, 4 ns period
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // hang guard, far above the expected run
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // register port: one-cycle strobes
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      {regAddr, wrData, wrStb} <= {a, d, 1'b1};
      @(posedge ref_clk);
      wrStb <= 1'b0;
   endtask
   // read data only valid in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      {regAddr, rdStb} <= {a, 1'b1};
      @(posedge ref_clk);
      rdStb <= 1'b0;
      #1;
      chk(rdData, exp, "register read");
   endtask
   // waits through a whole reset sequence, noting what it saw
   task automatic wait_boot();
      int i;
      {s, h} = '0;
      for (i = 0; i < 100 && sysReset !== 1'b1; i++) begin
         @(posedge ref_clk);
         #1;
      end
      for (i = 0; i < 400 && sysReset !== 1'b0; i++) begin
         s |= {debugLogicReset === 1'b1, fuseReload === 1'b1};
         h++;
         @(posedge ref_clk);
         #1;
      end
      chk({7'h0, sysReset}, 8'h00, "reset never ended");
   endtask
   // system must stay out of reset
   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         chk({7'h0, sysReset}, 8'h00, "unexpected reset");
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_power();
      wait_boot();
      chk({6'h0, s}, 8'h03, "power boot domains");
      // release edge and two synchroniser edges come before the reload
      chk(8'(h), 8'(3 + FUSE + STEP * startupSel), "power boot length");
      rd(rstc_pkg::ADDR_CAUSE, 8'h01);
      rd(rstc_pkg::ADDR_SWTRIG, 8'h00);
      rd(8'h05, 8'h00); // unmapped place reads zero
      wr(rstc_pkg::ADDR_CAUSE, 8'h00);
      rd(rstc_pkg::ADDR_CAUSE, 8'h01);
      wr(rstc_pkg::ADDR_CAUSE, 8'h01);
      rd(rstc_pkg::ADDR_CAUSE, 8'h00);
   endtask
   task automatic t_watchdog();
      i_far.raise(5'h08, 1);
      quiet(6);
      @(posedge ref_clk);
      watchdogEn <= 1'b1;
      i_far.raise(5'h08, 1);
      wait_boot();
      chk({6'h0, s}, 8'h01, "watchdog boot domains");
      rd(rstc_pkg::ADDR_CAUSE, 8'h08);
      wr(rstc_pkg::ADDR_CAUSE, 8'h3F);
   endtask
   // window already spent after four instructions
   task automatic t_locked();
      i_far.unlock(4);
      wr(rstc_pkg::ADDR_SWTRIG, 8'h01);
      quiet(10);
      rd(rstc_pkg::ADDR_CAUSE, 8'h00);
   endtask
   task automatic t_soft();
      i_far.unlock(3);
      wr(rstc_pkg::ADDR_SWTRIG, 8'h01);
      wait_boot();
      chk({6'h0, s}, 8'h01, "soft boot domains");
      chk(8'(h), 8'(1 + FUSE), "user reset got start-up delay");
      rd(rstc_pkg::ADDR_CAUSE, 8'h10);
      wr(rstc_pkg::ADDR_CAUSE, 8'h3F);
   endtask
   // pin ignored while its enable is off, held reset while low
   task automatic t_pin();
      i_far.raise(5'h04, 10);
      quiet(12);
      @(posedge ref_clk);
      pinResetEn <= 1'b1;
      fork
         i_far.raise(5'h04, 20);
         wait_boot();
      join
      chk({7'h0, h >= 20}, 8'h01, "pin reset too short");
      rd(rstc_pkg::ADDR_CAUSE, 8'h04);
      wr(rstc_pkg::ADDR_CAUSE, 8'h3F);
   endtask
   // brown-out and debug request together
   task automatic t_multi();
      i_far.raise(5'h02, 4);
      quiet(6);
      @(posedge ref_clk);
      brownoutEn <= 1'b1;
      i_far.raise(5'h12, 4);
      wait_boot();
      chk({6'h0, s}, 8'h03, "brown-out boot domains");
      rd(rstc_pkg::ADDR_CAUSE, 8'h22);
   endtask
   // memory scan keeps a debug-port reset going until the scan is done
   task automatic t_scan();
      @(posedge ref_clk);
      {memScanAtStart, memScanDone} <= 2'b10;
      i_far.raise(5'h10, 1);
      repeat (20) @(posedge ref_clk);
      #1;
      chk({7'h0, sysReset}, 8'h01, "scan wait cut short");
      @(posedge ref_clk);
      memScanDone <= 1'b1;
      wait_boot();
      chk({6'h0, s}, 8'h00, "debug reset domains");
      rd(rstc_pkg::ADDR_CAUSE, 8'h20);
      wr(rstc_pkg::ADDR_CAUSE, 8'h3F);
      memScanAtStart <= 1'b0;
   endtask
   // main sequence
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_power();
      t_watchdog();
      t_locked();
      t_soft();
      t_pin();
      t_scan();
      t_multi();
      wrap_up();
   end
endmodule // tb
